// [logic/vpa_an_engine.sv]
// Negotiation engine of the emulated link partner.
// Assumes start comes from logic on the same clock and reset is already synchronised.
`timescale 1ns/1ps

module vpa_an_engine (
	input  logic       ref_clk,
	input  logic       rst_n,
	input  logic       start,
	input  logic [3:0] local_abil,
	output logic       done,
	output logic       fail
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef enum logic [0:0] {
		ST_IDLE,
		ST_SETTLE
	} vpa_an_state_type;

	vpa_an_state_type state_q;
	vpa_an_state_type state_d;
	logic [3:0]       cnt_q;
	logic [3:0]       cnt_d;
	logic             done_q;
	logic             done_d;
	logic             fail_q;
	logic             fail_d;

	// The partner answers at once, so the only wait is the short settle count;
	// a new start during the wait restarts it rather than being dropped.
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		done_d  = 1'b0;
		fail_d  = fail_q;
		case (state_q)
			ST_IDLE: begin
				if (start) begin
					state_d = ST_SETTLE;
					cnt_d   = 4'h0;
				end
			end
			ST_SETTLE: begin
				if (start) begin
					cnt_d = 4'h0;
				end else if (cnt_q == vpa_pkg::AN_SETTLE_LAST) begin
					state_d = ST_IDLE;
					done_d  = 1'b1;
					// Failure means no common ability bit with the partner.
					fail_d  = ((local_abil & vpa_pkg::PARTNER_ABIL_SET) == 4'h0);
				end else begin
					cnt_d = cnt_q + 4'h1;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// Registers of the engine.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
			cnt_q   <= 4'h0;
			done_q  <= 1'b0;
			fail_q  <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			done_q  <= done_d;
			fail_q  <= fail_d;
		end
	end

	assign done = done_q;
	assign fail = fail_q;

endmodule

// [logic/vpa_partner_regs.sv]
// Read-only status registers of the emulated link partner: partner ability
// and negotiation expansion, reachable as 32-bit words and as 16-bit MII words.
// Assumes requests and advertisement inputs come from logic on ref_clk.
`timescale 1ns/1ps

module vpa_partner_regs (
	input  logic                     ref_clk,
	input  logic                     reset_n,
	input  vpa_pkg::vpa_bus_req_type bus_req,
	output vpa_pkg::vpa_bus_rsp_type bus_rsp,
	input  vpa_pkg::vpa_mii_req_type mii_req,
	output vpa_pkg::vpa_mii_rsp_type mii_rsp,
	input  logic                     local_adv_pause_sym,
	input  logic                     local_adv_pause_asym,
	input  logic [3:0]               local_adv_abil,
	input  logic                     an_restart
);

	// ------------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------------
	logic rst_meta_q;
	logic rst_sync_q;

	// Release is delayed two edges so that no flop leaves reset near a clock edge.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	// ------------------------------------------------------------------
	// Negotiation start and engine
	// ------------------------------------------------------------------
	logic boot_q;
	logic boot_d;
	logic an_start;
	logic an_done;
	logic an_fail;

	// Negotiation runs once by itself after reset, then on every restart.
	always_comb begin
		boot_d = 1'b0;
	end

	always_ff @(posedge ref_clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			boot_q <= 1'b1;
		end else begin
			boot_q <= boot_d;
		end
	end

	assign an_start = boot_q | an_restart;

	vpa_an_engine u_engine (
		.ref_clk    (ref_clk),
		.rst_n      (rst_sync_q),
		.start      (an_start),
		.local_abil (local_adv_abil),
		.done       (an_done),
		.fail       (an_fail)
	);

	// ------------------------------------------------------------------
	// Expansion status flags
	// ------------------------------------------------------------------
	logic bus_rd_exp;
	logic mii_rd_exp;
	logic page_q;
	logic page_d;
	logic able_q;
	logic able_d;

	assign bus_rd_exp = bus_req.rd && (bus_req.addr == vpa_pkg::AN_EXP_OFS);
	assign mii_rd_exp = mii_req.rd && (mii_req.index == vpa_pkg::AN_EXP_IDX);

	// A page arriving in the same cycle as a clearing read is kept, so the
	// set term is checked first; writes never reach these flags.
	always_comb begin
		page_d = page_q;
		able_d = able_q;
		if (an_done) begin
			page_d = 1'b1;
			able_d = !an_fail;
		end else if (bus_rd_exp || mii_rd_exp) begin
			page_d = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			page_q <= vpa_pkg::PAGE_RX_RST;
			able_q <= vpa_pkg::AN_ABLE_RST;
		end else begin
			page_q <= page_d;
			able_q <= able_d;
		end
	end

	// ------------------------------------------------------------------
	// Register contents
	// ------------------------------------------------------------------
	// Both access paths share one decoder so the 16-bit and 32-bit views cannot drift.
	function automatic logic [15:0] reg_word(input logic [4:0] idx, input logic sym,
	                                         input logic asym, input logic page,
	                                         input logic able);
		logic [15:0] w;
		logic [1:0]  p;
		w = 16'h0000;
		p = vpa_pkg::pause_map(sym, asym);
		if (idx == vpa_pkg::PARTNER_ABIL_IDX) begin
			w[vpa_pkg::SEL_MSB:vpa_pkg::SEL_LSB]   = vpa_pkg::SEL_IEEE_802_3;
			w[vpa_pkg::ABIL_MSB:vpa_pkg::ABIL_LSB] = vpa_pkg::PARTNER_ABIL_SET;
			w[vpa_pkg::T4_BIT]                     = 1'b0;
			w[vpa_pkg::PAUSE_SYM_BIT]              = p[0];
			w[vpa_pkg::PAUSE_ASYM_BIT]             = p[1];
			w[vpa_pkg::REMOTE_FAULT_BIT]           = 1'b0;
		end else if (idx == vpa_pkg::AN_EXP_IDX) begin
			w[vpa_pkg::EXP_PDF_BIT]        = 1'b0;
			w[vpa_pkg::EXP_PARTNER_NP_BIT] = 1'b0;
			w[vpa_pkg::EXP_LOCAL_NP_BIT]   = 1'b0;
			w[vpa_pkg::EXP_PAGE_RX_BIT]    = page;
			w[vpa_pkg::EXP_AN_ABLE_BIT]    = able;
		end
		return w;
	endfunction

	// ------------------------------------------------------------------
	// Word-wide read port
	// ------------------------------------------------------------------
	logic [4:0]  bus_idx;
	logic        bus_rsp_valid_q;
	logic        bus_rsp_valid_d;
	logic [31:0] bus_rsp_data_q;
	logic [31:0] bus_rsp_data_d;

	// Byte address to register index; unmapped addresses land on an empty index.
	always_comb begin
		bus_idx = 5'h1f;
		if (bus_req.addr == vpa_pkg::PARTNER_ABIL_OFS) begin
			bus_idx = vpa_pkg::PARTNER_ABIL_IDX;
		end else if (bus_req.addr == vpa_pkg::AN_EXP_OFS) begin
			bus_idx = vpa_pkg::AN_EXP_IDX;
		end
	end

	// Data is captured before the clearing read takes effect, so the reader sees the flag.
	always_comb begin
		bus_rsp_valid_d = bus_req.rd || bus_req.wr;
		bus_rsp_data_d  = 32'h0000_0000;
		if (bus_req.rd) begin
			bus_rsp_data_d = {16'h0000, reg_word(bus_idx, local_adv_pause_sym,
				local_adv_pause_asym, page_q, able_q)};
		end
	end

	always_ff @(posedge ref_clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			bus_rsp_valid_q <= 1'b0;
			bus_rsp_data_q  <= 32'h0000_0000;
		end else begin
			bus_rsp_valid_q <= bus_rsp_valid_d;
			bus_rsp_data_q  <= bus_rsp_data_d;
		end
	end

	assign bus_rsp.valid = bus_rsp_valid_q;
	assign bus_rsp.data  = bus_rsp_data_q;

	// ------------------------------------------------------------------
	// Serial management read port
	// ------------------------------------------------------------------
	logic        mii_rsp_valid_q;
	logic        mii_rsp_valid_d;
	logic [15:0] mii_rsp_data_q;
	logic [15:0] mii_rsp_data_d;

	// The serial view carries only the low half word of each register.
	always_comb begin
		mii_rsp_valid_d = mii_req.rd;
		mii_rsp_data_d  = 16'h0000;
		if (mii_req.rd) begin
			mii_rsp_data_d = reg_word(mii_req.index, local_adv_pause_sym,
				local_adv_pause_asym, page_q, able_q);
		end
	end

	always_ff @(posedge ref_clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			mii_rsp_valid_q <= 1'b0;
			mii_rsp_data_q  <= 16'h0000;
		end else begin
			mii_rsp_valid_q <= mii_rsp_valid_d;
			mii_rsp_data_q  <= mii_rsp_data_d;
		end
	end

	assign mii_rsp.valid = mii_rsp_valid_q;
	assign mii_rsp.data  = mii_rsp_data_q;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	logic rd_partner;
	logic rd_exp_only;

	assign rd_partner  = bus_req.rd && (bus_req.addr == vpa_pkg::PARTNER_ABIL_OFS);
	assign rd_exp_only = bus_rd_exp && !mii_req.rd;

	sequence s_start_seen;
		an_start ##1 !an_start;
	endsequence

	sequence s_done_within;
		##[1:4] an_done;
	endsequence

	property p_abil_ones;
		@(posedge ref_clk) disable iff (!rst_sync_q)
		rd_partner |=> bus_rsp.data[8:5] == 4'hf;
	endproperty
	a_abil_ones: assert property (p_abil_ones) else $error("Partner ability bits not all one.");

	property p_selector;
		@(posedge ref_clk) disable iff (!rst_sync_q)
		rd_partner |=> bus_rsp.valid && bus_rsp.data[4:0] == 5'h01;
	endproperty
	a_selector: assert property (p_selector) else $error("Selector field is wrong.");

	property p_upper_zero;
		@(posedge ref_clk) disable iff (!rst_sync_q)
		bus_rsp.valid |-> bus_rsp.data[31:16] == 16'h0000;
	endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("Upper half word not zero.");

	property p_pause_sym;
		@(posedge ref_clk) disable iff (!rst_sync_q)
		rd_partner && !local_adv_pause_asym |=>
			bus_rsp.data[10] == $past(local_adv_pause_sym) && !bus_rsp.data[11];
	endproperty
	a_pause_sym: assert property (p_pause_sym) else $error("Symmetric pause mirror wrong.");

	property p_pause_asym;
		@(posedge ref_clk) disable iff (!rst_sync_q)
		rd_partner && local_adv_pause_asym |=>
			bus_rsp.data[11] && bus_rsp.data[10] == !$past(local_adv_pause_sym);
	endproperty
	a_pause_asym: assert property (p_pause_asym) else $error("Asymmetric pause mirror wrong.");

	property p_no_pdf;
		@(posedge ref_clk) disable iff (!rst_sync_q)
		mii_req.rd && mii_req.index == 5'h06 |=> mii_rsp.valid && !mii_rsp.data[4];
	endproperty
	a_no_pdf: assert property (p_no_pdf) else $error("Parallel detection fault set.");

	property p_no_next_page;
		@(posedge ref_clk) disable iff (!rst_sync_q)
		bus_rd_exp |=> bus_rsp.data[3:2] == 2'b00;
	endproperty
	a_no_next_page: assert property (p_no_next_page) else $error("Next page bit set.");

	property p_page_clear;
		@(posedge ref_clk) disable iff (!rst_sync_q)
		rd_exp_only && !an_done |=> !page_q ##0 bus_rsp.data[1] == $past(page_q);
	endproperty
	a_page_clear: assert property (p_page_clear) else $error("Page flag not cleared by read.");

	property p_page_set;
		@(posedge ref_clk) disable iff (!rst_sync_q)
		an_done |=> page_q && able_q == !an_fail;
	endproperty
	a_page_set: assert property (p_page_set) else $error("Page flag or able flag not set.");

	property p_quick_answer;
		@(posedge ref_clk) disable iff (!rst_sync_q)
		s_start_seen |-> s_done_within;
	endproperty
	a_quick_answer: assert property (p_quick_answer) else $error("Partner answer is late.");

	property p_no_t4_fault;
		@(posedge ref_clk) disable iff (!rst_sync_q)
		rd_partner |=> !bus_rsp.data[9] && !bus_rsp.data[13];
	endproperty
	a_no_t4_fault: assert property (p_no_t4_fault) else $error("T4 or fault bit set.");

	property p_write_ignored;
		@(posedge ref_clk) disable iff (!rst_sync_q)
		bus_req.wr && !bus_req.rd && !mii_req.rd && !an_done |=>
			page_q == $past(page_q) && bus_rsp.data == 32'h0000_0000;
	endproperty
	a_write_ignored: assert property (p_write_ignored) else $error("Write changed state.");

endmodule

// [logic/vpa_pkg.sv]
// Package of the emulated link partner status block: offsets, field positions,
// reset values, timing counts and the request and answer carriers.
// Assumes a single 125 MHz system clock and nothing else from its surroundings.
package vpa_pkg;

	// ------------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------------
	localparam int unsigned ADDR_W             = 12;
	localparam logic [11:0] PARTNER_ABIL_OFS   = 12'h1d4;
	localparam logic [11:0] AN_EXP_OFS         = 12'h1d8;
	localparam logic [4:0]  PARTNER_ABIL_IDX   = 5'h05;
	localparam logic [4:0]  AN_EXP_IDX         = 5'h06;

	// ------------------------------------------------------------------
	// Field positions and fixed values
	// ------------------------------------------------------------------
	localparam int unsigned SEL_LSB            = 0;
	localparam int unsigned SEL_MSB            = 4;
	localparam logic [4:0]  SEL_IEEE_802_3     = 5'h01;
	localparam int unsigned ABIL_LSB           = 5;
	localparam int unsigned ABIL_MSB           = 8;
	localparam logic [3:0]  PARTNER_ABIL_SET   = 4'hf;
	localparam int unsigned T4_BIT             = 9;
	localparam int unsigned PAUSE_SYM_BIT      = 10;
	localparam int unsigned PAUSE_ASYM_BIT     = 11;
	localparam int unsigned REMOTE_FAULT_BIT   = 13;
	localparam int unsigned EXP_AN_ABLE_BIT    = 0;
	localparam int unsigned EXP_PAGE_RX_BIT    = 1;
	localparam int unsigned EXP_LOCAL_NP_BIT   = 2;
	localparam int unsigned EXP_PARTNER_NP_BIT = 3;
	localparam int unsigned EXP_PDF_BIT        = 4;
	localparam logic        PAGE_RX_RST        = 1'b0;
	localparam logic        AN_ABLE_RST        = 1'b1;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS      = 8;
	localparam int unsigned AN_SETTLE_NS       = 16;
	localparam int unsigned AN_SETTLE_CYC      =
		(AN_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0]  AN_SETTLE_LAST     = 4'(AN_SETTLE_CYC - 1);

	// ------------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------------
	typedef struct packed {
		logic              rd;
		logic              wr;
		logic [ADDR_W-1:0] addr;
		logic [31:0]       wdata;
	} vpa_bus_req_type;

	typedef struct packed {
		logic        valid;
		logic [31:0] data;
	} vpa_bus_rsp_type;

	typedef struct packed {
		logic       rd;
		logic [4:0] index;
	} vpa_mii_req_type;

	typedef struct packed {
		logic        valid;
		logic [15:0] data;
	} vpa_mii_rsp_type;

	// Partner pause answer {asym, sym} for a local {asym, sym} advertisement.
	function automatic logic [1:0] pause_map(input logic adv_sym, input logic adv_asym);
		logic [1:0] r;
		r = 2'h0;
		case ({adv_asym, adv_sym})
			2'b01: r = 2'b01;
			2'b10: r = 2'b11;
			2'b11: r = 2'b10;
			default: r = 2'b00;
		endcase
		return r;
	endfunction

endpackage

// [tb/virtual_phy_autoneg_partner_regs_tb.sv]
// Self-checking bench of the emulated link partner status registers.
// Assumes the register block and the management station model compile first.
`timescale 1ns/1ps

`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin errors++; \
	$display("ERROR t=%0t got %h exp %h", $time, got, exp); end end

module virtual_phy_autoneg_partner_regs_tb;
	logic                     ref_clk;
	logic                     reset_n;
	vpa_pkg::vpa_bus_req_type bus_req;
	vpa_pkg::vpa_bus_rsp_type bus_rsp;
	vpa_pkg::vpa_mii_req_type mii_req;
	vpa_pkg::vpa_mii_rsp_type mii_rsp;
	logic                     sym;
	logic                     asym;
	logic [3:0]               abil;
	logic                     an_restart;
	int                       errors;
	int                       n_compared;
	int                       cycles;
	logic [31:0]              rdata;
	logic [15:0]              mdata;
	logic                     ok;
	logic [1:0]               pmap [4];

	// ----------------------------------------------------------------
	// Clock, design and far side
	// ----------------------------------------------------------------
	// Free-running 125 MHz clock.
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	vpa_partner_regs uut (
		.ref_clk              (ref_clk),
		.reset_n              (reset_n),
		.bus_req              (bus_req),
		.bus_rsp              (bus_rsp),
		.mii_req              (mii_req),
		.mii_rsp              (mii_rsp),
		.local_adv_pause_sym  (sym),
		.local_adv_pause_asym (asym),
		.local_adv_abil       (abil),
		.an_restart           (an_restart)
	);

	vpa_mgmt_host host (
		.ref_clk (ref_clk),
		.mii_rsp (mii_rsp),
		.mii_req (mii_req)
	);

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	// Prints the counts and the verdict, then ends the run.
	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// One word access; a missing answer counts as a mismatch.
	task automatic bus_xfer(input logic wr, input logic [11:0] addr, output logic [31:0] data);
		logic got;
		got = 1'b0;
		data = 32'h0;
		@(posedge ref_clk);
		#1;
		bus_req = '{rd: ~wr, wr: wr, addr: addr, wdata: 32'hffff_ffff};
		@(posedge ref_clk);
		#1;
		bus_req.rd = 1'b0;
		bus_req.wr = 1'b0;
		bus_req.addr = ~addr;
		for (int i = 0; i < 3 && !got; i++) begin
			if (bus_rsp.valid === 1'b1) begin
				got = 1'b1;
				data = bus_rsp.data;
			end else begin
				@(posedge ref_clk);
				#1;
			end
		end
		`CHK(got, 1'b1)
	endtask

	// Reads a word and compares it with the expected value.
	task automatic rd_chk(input logic [11:0] addr, input logic [31:0] exp);
		bus_xfer(1'b0, addr, rdata);
		`CHK(rdata, exp)
	endtask

	// Pulses restart for one cycle and lets the settle time of two cycles pass.
	task automatic renegotiate(input logic [3:0] adv);
		@(posedge ref_clk);
		#1;
		abil = adv;
		an_restart = 1'b1;
		@(posedge ref_clk);
		#1;
		an_restart = 1'b0;
		repeat (4) @(posedge ref_clk);
	endtask

	// ----------------------------------------------------------------
	// Watchdog
	// ----------------------------------------------------------------
	// The tests need under a hundred cycles; a hang stops well past that.
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 3000) begin
			errors++;
			conclude();
		end
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	// Partner pause answer indexed by the local {asym, sym} advertisement.
	initial begin
		pmap = '{2'b00, 2'b01, 2'b11, 2'b10};
		errors = 0;
		n_compared = 0;
		cycles = 0;
		reset_n = 1'b0;
		bus_req = '0;
		sym = 1'b0;
		asym = 1'b0;
		abil = 4'hf;
		an_restart = 1'b0;
		repeat (6) @(posedge ref_clk);
		#1;
		reset_n = 1'b1;
		repeat (8) @(posedge ref_clk);

		rd_chk(vpa_pkg::AN_EXP_OFS, 32'h0000_0003);
		rd_chk(vpa_pkg::AN_EXP_OFS, 32'h0000_0001);
		host.mii_read(vpa_pkg::AN_EXP_IDX, mdata, ok);
		`CHK({ok, mdata}, 17'h1_0001)
		$display("test page flag after reset done");

		for (int p = 0; p < 4; p++) begin
			sym = p[0];
			asym = p[1];
			repeat (2) @(posedge ref_clk);
			rd_chk(vpa_pkg::PARTNER_ABIL_OFS, {20'h0, pmap[p], 10'h1e1});
			host.mii_read(vpa_pkg::PARTNER_ABIL_IDX, mdata, ok);
			`CHK({ok, mdata}, {1'b1, 4'h0, pmap[p], 10'h1e1})
		end
		$display("test pause mirror done");

		bus_xfer(1'b1, vpa_pkg::PARTNER_ABIL_OFS, rdata);
		`CHK(rdata, 32'h0)
		rd_chk(vpa_pkg::PARTNER_ABIL_OFS, 32'h0000_09e1);
		bus_xfer(1'b1, vpa_pkg::AN_EXP_OFS, rdata);
		`CHK(rdata, 32'h0)
		rd_chk(vpa_pkg::AN_EXP_OFS, 32'h0000_0001);
		rd_chk(12'h1dc, 32'h0);
		$display("test writes and unmapped done");

		// No common ability makes the partner not negotiation able.
		renegotiate(4'h0);
		rd_chk(vpa_pkg::AN_EXP_OFS, 32'h0000_0002);
		renegotiate(4'h2);
		rd_chk(vpa_pkg::AN_EXP_OFS, 32'h0000_0003);
		rd_chk(vpa_pkg::AN_EXP_OFS, 32'h0000_0001);
		$display("test renegotiation done");

		// A reset in mid-run empties both answers, and negotiation then runs again
		// by itself; the serial read must clear the page flag just as a word read does.
		@(posedge ref_clk);
		#1;
		reset_n = 1'b0;
		repeat (2) @(posedge ref_clk);
		#1;
		`CHK({bus_rsp, mii_rsp}, 50'h0)
		reset_n = 1'b1;
		repeat (8) @(posedge ref_clk);
		host.mii_read(vpa_pkg::AN_EXP_IDX, mdata, ok);
		`CHK({ok, mdata}, 17'h1_0003)
		rd_chk(vpa_pkg::AN_EXP_OFS, 32'h0000_0001);
		$display("test mid-run reset done");
		conclude();
	end
endmodule

// [tb/vpa_mgmt_host.sv]
// Model of the management station that reads the block over MII.
// Assumes the block answers with a one-cycle valid pulse within three edges.
`timescale 1ns/1ps

module vpa_mgmt_host (
	input  logic                     ref_clk,
	input  vpa_pkg::vpa_mii_rsp_type mii_rsp,
	output vpa_pkg::vpa_mii_req_type mii_req
);
	// ----------------------------------------------------------------
	// Idle state
	// ----------------------------------------------------------------
	// Start idle so the block sees no request during reset.
	initial begin
		mii_req = '0;
	end

	// ----------------------------------------------------------------
	// Read cycle
	// ----------------------------------------------------------------
	// One read of a 16-bit register; the index is inverted once released
	// so that the block cannot lean on a stale value.
	task automatic mii_read(input logic [4:0] index, output logic [15:0] data,
		output logic ok);
		ok = 1'b0;
		data = 16'h0000;
		@(posedge ref_clk);
		#1;
		mii_req.rd = 1'b1;
		mii_req.index = index;
		@(posedge ref_clk);
		#1;
		mii_req.rd = 1'b0;
		mii_req.index = ~index;
		for (int i = 0; i < 3 && !ok; i++) begin
			if (mii_rsp.valid === 1'b1) begin
				ok = 1'b1;
				data = mii_rsp.data;
			end else begin
				@(posedge ref_clk);
				#1;
			end
		end
	endtask
endmodule
